//--- sau_regs.svh
// constants of the saturating add/subtract datapath
// assumes a single core clock and a 32-bit register file
`ifndef SAU_REGS_SVH
`define SAU_REGS_SVH
`define SAU_WORD_W 32
`define SAU_HALF_W 16
`define SAU_BYTE_W 8
`define SAU_REG_IDX_W 4
`define SAU_SP_IDX 4'hd
`define SAU_PC_IDX 4'hf
`define SAU_FLAG_RST 1'b0
`define SAU_WORD_RST 32'h0000_0000
`endif

//--- sau_pkg.sv
// types shared by the saturating arithmetic unit
// assumes sau_regs.svh for widths
`include "sau_regs.svh"
package sau_pkg;
    // operation selector
    typedef enum logic [3:0] {
        sau_op_add_word,
        sau_op_sub_word,
        sau_op_add_bytes,
        sau_op_sub_bytes,
        sau_op_add_halves,
        sau_op_sub_halves,
        sau_op_add_sub_exch,
        sau_op_sub_add_exch,
        sau_op_double_add,
        sau_op_double_sub,
        sau_op_uadd_sub_exch,
        sau_op_usub_add_exch
    } sau_op_type;

    // one issued operation from decode
    typedef struct packed {
        sau_op_type op;
        logic cond_pass;
        logic dest_given;
        logic [`SAU_REG_IDX_W-1:0] dest_idx;
        logic [`SAU_REG_IDX_W-1:0] first_idx;
        logic [`SAU_WORD_W-1:0] first_operand;
        logic [`SAU_WORD_W-1:0] second_operand;
    } sau_req_type;

    // result toward the register file
    typedef struct packed {
        logic wr_en;
        logic [`SAU_REG_IDX_W-1:0] wr_idx;
        logic [`SAU_WORD_W-1:0] wr_data;
    } sau_rsp_type;
endpackage

//--- sau_lane_sat.sv
// one saturating add/subtract lane, signed or unsigned
// assumes plain combinational use inside the datapath
module sau_lane_sat #(
    parameter int W = 16
) (
    // operands and mode
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic subtract,
    input wire logic is_unsigned,
    // clamped result
    output logic [W-1:0] y,
    output logic saturated
);
    logic [W:0] ext_a;
    logic [W:0] ext_b;
    logic [W:0] raw;

    initial begin
        if (W < 2) $error("lane width too small");
    end

    // extend one bit so the lane never carries out of itself
    always_comb begin
        ext_a = is_unsigned ? {1'b0, a} : {a[W-1], a};
        ext_b = is_unsigned ? {1'b0, b} : {b[W-1], b};
        raw = subtract ? ext_a - ext_b : ext_a + ext_b;
        saturated = 1'b0;
        y = raw[W-1:0];
        if (is_unsigned) begin
            if (raw[W]) begin
                saturated = 1'b1;
                y = subtract ? '0 : '1;
            end
        end else if (raw[W] != raw[W-1]) begin
            saturated = 1'b1;
            y = {raw[W], {(W-1){~raw[W]}}};
        end
    end
endmodule

//--- sau_unit.sv
// saturating add/subtract datapath with sticky saturation flag
// assumes decode never issues the stack pointer or program counter
`include "sau_regs.svh"
module sau_unit (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // operation issue
    input wire logic req_valid,
    input wire sau_pkg::sau_req_type req,
    // special-register access to the status word
    input wire logic write_special_reg,
    input wire logic write_sat_flag,
    // result and status
    output sau_pkg::sau_rsp_type rsp,
    output logic read_special_reg_sat,
    output logic illegal_reg_seen
);
    import sau_pkg::*;

    logic [`SAU_WORD_W-1:0] a;
    logic [`SAU_WORD_W-1:0] b;
    logic [`SAU_WORD_W-1:0] result;
    logic sub_sel;
    logic unsigned_sel;
    logic [1:0] lane_sub;
    logic [1:0] half_sat;
    logic [3:0] byte_sat;
    logic [31:0] half_y;
    logic [31:0] byte_y;
    logic [31:0] hx_a;
    logic [31:0] hx_b;
    logic [31:0] word_y;
    logic word_sat;
    logic [31:0] dbl_y;
    logic dbl_sat;
    logic [31:0] word_b;
    logic word_sub;
    logic set_flag;
    logic sat_flag_reg;
    logic sat_flag_next;
    sau_rsp_type rsp_next;

    assign a = req.first_operand;
    assign b = req.second_operand;

    // doubling step, saturated to 32 bits
    sau_lane_sat #(.W(`SAU_WORD_W)) u_double (
        .a(b), .b(b), .subtract(1'b0), .is_unsigned(1'b0),
        .y(dbl_y), .saturated(dbl_sat)
    );

    // word step takes doubled operand for double forms
    always_comb begin
        word_b = b;
        word_sub = (req.op == sau_op_sub_word);
        if (req.op == sau_op_double_add || req.op == sau_op_double_sub) begin
            word_b = dbl_y;
            word_sub = (req.op == sau_op_double_sub);
        end
    end

    sau_lane_sat #(.W(`SAU_WORD_W)) u_word (
        .a(a), .b(word_b), .subtract(word_sub), .is_unsigned(1'b0),
        .y(word_y), .saturated(word_sat)
    );

    // halfword operand routing, swapped for exchange forms
    always_comb begin
        hx_a = a;
        hx_b = b;
        unsigned_sel = 1'b0;
        sub_sel = (req.op == sau_op_sub_halves);
        lane_sub = {sub_sel, sub_sel};
        case (req.op)
            sau_op_add_sub_exch, sau_op_uadd_sub_exch: begin
                hx_b = {b[`SAU_HALF_W-1:0], b[`SAU_WORD_W-1:`SAU_HALF_W]};
                lane_sub = 2'b01;
            end
            sau_op_sub_add_exch, sau_op_usub_add_exch: begin
                hx_b = {b[`SAU_HALF_W-1:0], b[`SAU_WORD_W-1:`SAU_HALF_W]};
                lane_sub = 2'b10;
            end
            default: begin
            end
        endcase
        if (req.op == sau_op_uadd_sub_exch || req.op == sau_op_usub_add_exch) begin
            unsigned_sel = 1'b1;
        end
    end

    // independent half lanes, clamped signed or unsigned
    for (genvar i = 0; i < 2; i++) begin : g_half
        sau_lane_sat #(.W(`SAU_HALF_W)) u_half (
            .a(hx_a[i*`SAU_HALF_W +: `SAU_HALF_W]), .b(hx_b[i*`SAU_HALF_W +: `SAU_HALF_W]),
            .subtract(lane_sub[i]), .is_unsigned(unsigned_sel),
            .y(half_y[i*`SAU_HALF_W +: `SAU_HALF_W]), .saturated(half_sat[i])
        );
    end

    // independent byte lanes
    for (genvar i = 0; i < 4; i++) begin : g_byte
        sau_lane_sat #(.W(`SAU_BYTE_W)) u_byte (
            .a(a[i*`SAU_BYTE_W +: `SAU_BYTE_W]), .b(b[i*`SAU_BYTE_W +: `SAU_BYTE_W]),
            .subtract(req.op == sau_op_sub_bytes), .is_unsigned(1'b0),
            .y(byte_y[i*`SAU_BYTE_W +: `SAU_BYTE_W]), .saturated(byte_sat[i])
        );
    end

    // result select and flag set decision
    always_comb begin
        result = word_y;
        set_flag = 1'b0;
        case (req.op)
            sau_op_add_word, sau_op_sub_word: begin
                set_flag = word_sat;
            end
            sau_op_double_add, sau_op_double_sub: begin
                set_flag = word_sat | dbl_sat;
            end
            sau_op_add_bytes, sau_op_sub_bytes: begin
                result = byte_y;
            end
            default: begin
                result = half_y;
            end
        endcase
    end

    // write-back; destination defaults to first operand
    always_comb begin
        rsp_next.wr_en = clk_en & req_valid & req.cond_pass;
        rsp_next.wr_idx = req.dest_given ? req.dest_idx : req.first_idx;
        rsp_next.wr_data = result;
    end

    // sticky flag: saturation set wins over a simultaneous clear
    always_comb begin
        sat_flag_next = sat_flag_reg;
        if (write_special_reg) begin
            sat_flag_next = write_sat_flag;
        end
        if (req_valid && req.cond_pass && set_flag) begin
            sat_flag_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sat_flag_reg <= `SAU_FLAG_RST;
        end else if (clk_en) begin
            sat_flag_reg <= sat_flag_next;
        end
    end

    // registered result toward the register file
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp <= '{wr_en: 1'b0, wr_idx: '0, wr_data: `SAU_WORD_RST};
        end else begin
            rsp.wr_en <= rsp_next.wr_en;
            if (clk_en) begin
                rsp.wr_idx <= rsp_next.wr_idx;
                rsp.wr_data <= rsp_next.wr_data;
            end
        end
    end

    // status word view of the flag
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            read_special_reg_sat <= `SAU_FLAG_RST;
        end else if (clk_en) begin
            read_special_reg_sat <= sat_flag_next;
        end
    end

    // diagnostic: decode named stack pointer or program counter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            illegal_reg_seen <= 1'b0;
        end else if (clk_en) begin
            illegal_reg_seen <= req_valid && (
                req.first_idx == `SAU_SP_IDX || req.first_idx == `SAU_PC_IDX ||
                (req.dest_given && (req.dest_idx == `SAU_SP_IDX ||
                                    req.dest_idx == `SAU_PC_IDX)));
        end
    end
    // condition flags N Z C V have no path in this block at all
endmodule

//--- sau_unit_monitor.sv
// assertions on the saturating unit ports
// assumes one core clock domain, bound onto sau_unit
module sau_unit_monitor import sau_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // issue side
    input wire logic req_valid,
    input wire sau_pkg::sau_req_type req,
    input wire logic write_special_reg,
    input wire logic write_sat_flag,
    // result side
    input wire sau_pkg::sau_rsp_type rsp,
    input wire logic read_special_reg_sat,
    input wire logic illegal_reg_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic go;
    logic ovf;
    logic lane_op;
    logic [31:0] sum_w;
    // accepted issue, upward word overflow, lane forms
    assign go = clk_en && req_valid && req.cond_pass;
    assign sum_w = req.first_operand + req.second_operand;
    assign ovf = req.op == sau_op_add_word && !req.first_operand[31]
        && !req.second_operand[31] && sum_w[31];
    assign lane_op = req.op inside {sau_op_add_bytes, sau_op_sub_bytes,
        sau_op_add_halves, sau_op_sub_halves};
    wr_pulse_a: assert property (go |=> rsp.wr_en)
        else $error("missing write");
    no_write_a: assert property (!go |=> !rsp.wr_en)
        else $error("stray write");
    dest_default_a: assert property (go && !req.dest_given
        |=> rsp.wr_idx == $past(req.first_idx)) else $error("wrong default destination");
    lane_flag_a: assert property (clk_en && req_valid && lane_op && !write_special_reg
        |=> $stable(read_special_reg_sat)) else $error("lane op moved flag");
    flag_clear_a: assert property (clk_en && write_special_reg && !write_sat_flag
        && !req_valid |=> !read_special_reg_sat) else $error("flag not cleared");
    flag_fall_a: assert property ($fell(read_special_reg_sat)
        |-> $past(clk_en) && $past(write_special_reg)) else $error("flag fell alone");
    flag_write_a: assert property (clk_en && write_special_reg && write_sat_flag
        |=> read_special_reg_sat) else $error("flag write lost");
    word_clamp_a: assert property (go && ovf |=> rsp.wr_data == 32'h7fffffff
        && read_special_reg_sat) else $error("word clamp wrong");
endmodule
bind sau_unit sau_unit_monitor sau_unit_monitor_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .clk_en(clk_en), .req_valid(req_valid), .req(req), .write_special_reg(write_special_reg),
    .write_sat_flag(write_sat_flag), .rsp(rsp), .read_special_reg_sat(read_special_reg_sat),
    .illegal_reg_seen(illegal_reg_seen));

//--- sau_regfile_model.sv
// register file model taking the unit's write-backs
// assumes a registered write port on the core clock
module sau_regfile_model import sau_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // write-back from the unit
    input wire sau_pkg::sau_rsp_type rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] regs [16];
    // store each accepted write
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            regs <= '{default: 32'h0};
        end else if (rsp.wr_en) begin
            regs[rsp.wr_idx] <= rsp.wr_data;
        end
    end
endmodule

//--- tb.sv
// self-checking bench for the saturating unit
// assumes sau_unit, its bound monitor and the register file model
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sau_pkg::*;
    logic sys_clk, arst_n, clk_en, req_valid, write_special_reg, write_sat_flag;
    logic read_special_reg_sat, illegal_reg_seen;
    sau_req_type req;
    sau_rsp_type rsp;
    int err_count, n_tests, cyc;
    sau_unit sau_unit_i (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .req_valid(req_valid), .req(req), .write_special_reg(write_special_reg),
        .write_sat_flag(write_sat_flag), .rsp(rsp),
        .read_special_reg_sat(read_special_reg_sat), .illegal_reg_seen(illegal_reg_seen));
    sau_regfile_model sau_regfile_model_i (.sys_clk(sys_clk), .arst_n(arst_n), .rsp(rsp));
    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            final_report();
        end
    end
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one issue, held back to back; result judged a cycle later
    task automatic run(sau_op_type op, logic [31:0] a, logic [31:0] b, logic cp,
            logic [31:0] exp, logic exq);
        req = '{op, cp, 1'b0, 4'h7, 4'h3, a, b};
        req_valid = 1'b1;
        @(negedge sys_clk);
        chk({31'h0, rsp.wr_en}, {31'h0, cp});
        if (cp) chk(rsp.wr_data, exp);
        if (cp) chk({28'h0, rsp.wr_idx}, 32'h3);
        chk({31'h0, read_special_reg_sat}, {31'h0, exq});
        chk({31'h0, illegal_reg_seen}, 32'h0);
    endtask
    task automatic idle();
        req_valid = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic set_flag(logic v);
        write_special_reg = 1'b1;
        write_sat_flag = v;
        @(negedge sys_clk);
        write_special_reg = 1'b0;
        chk({31'h0, read_special_reg_sat}, {31'h0, v});
        @(negedge sys_clk);
    endtask
    task automatic t_word();
        set_flag(1'b1);
        set_flag(1'b0);
        run(sau_op_add_word, 32'h7fffffff, 32'h1, 1'b1, 32'h7fffffff, 1'b1);
        run(sau_op_add_word, 32'h5, 32'h3, 1'b1, 32'h8, 1'b1);
        idle();
        set_flag(1'b0);
        run(sau_op_sub_word, 32'h80000000, 32'h1, 1'b1, 32'h80000000, 1'b1);
        idle();
        set_flag(1'b0);
    endtask
    task automatic t_lanes();
        run(sau_op_add_bytes, 32'h7f8001ff, 32'h01ff01ff, 1'b1, 32'h7f8002fe, 1'b0);
        run(sau_op_sub_bytes, 32'h807f0010, 32'h01ff0120, 1'b1, 32'h807ffff0, 1'b0);
        run(sau_op_add_halves, 32'h7fff8000, 32'h0001ffff, 1'b1, 32'h7fff8000, 1'b0);
        run(sau_op_add_halves, 32'h0000ffff, 32'h00000001, 1'b1, 32'h0, 1'b0);
        run(sau_op_sub_halves, 32'h00018000, 32'h80000001, 1'b1, 32'h7fff8000, 1'b0);
    endtask
    task automatic t_exch();
        run(sau_op_add_sub_exch, 32'h10002000, 32'h00030005, 1'b1, 32'h10051ffd, 1'b0);
        run(sau_op_sub_add_exch, 32'h10002000, 32'h00030005, 1'b1, 32'h0ffb2003, 1'b0);
        run(sau_op_add_sub_exch, 32'h7fff8000, 32'h00010001, 1'b1, 32'h7fff8000, 1'b0);
        run(sau_op_sub_add_exch, 32'h80007fff, 32'h00010001, 1'b1, 32'h80007fff, 1'b0);
        run(sau_op_uadd_sub_exch, 32'hffff0001, 32'h00020005, 1'b1, 32'hffff0000, 1'b0);
        run(sau_op_usub_add_exch, 32'h0001fff0, 32'h01000002, 1'b1, 32'h0000ffff, 1'b0);
    endtask
    task automatic t_double();
        run(sau_op_double_add, 32'h5, 32'h3, 1'b1, 32'hb, 1'b0);
        run(sau_op_double_sub, 32'h9, 32'h2, 1'b1, 32'h5, 1'b0);
        run(sau_op_double_add, 32'h80000000, 32'h40000000, 1'b1, 32'hffffffff, 1'b1);
        idle();
        set_flag(1'b0);
        run(sau_op_double_sub, 32'h0, 32'hc0000000, 1'b1, 32'h7fffffff, 1'b1);
        idle();
        set_flag(1'b0);
    endtask
    task automatic t_cond();
        run(sau_op_sub_word, 32'h80000000, 32'h1, 1'b0, 32'h0, 1'b0);
        req.dest_given = 1'b1;
        req.cond_pass = 1'b1;
        @(negedge sys_clk);
        chk({28'h0, rsp.wr_idx}, 32'h7);
        chk({31'h0, read_special_reg_sat}, 32'h1);
        clk_en = 1'b0;
        @(negedge sys_clk);
        chk({31'h0, rsp.wr_en}, 32'h0);
        clk_en = 1'b1;
        idle();
        chk(sau_regfile_model_i.regs[3], 32'h7fffffff);
        chk(sau_regfile_model_i.regs[7], 32'h80000000);
    endtask
    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        req_valid = 1'b0;
        write_special_reg = 1'b0;
        write_sat_flag = 1'b0;
        req = '0;
        repeat (3) @(negedge sys_clk);
        arst_n = 1'b1;
        t_word();
        t_lanes();
        t_exch();
        t_double();
        t_cond();
        final_report();
    end
endmodule
